/* File: rtl/wcs_pkg.sv */
// Constants, types and word order for the waveform capture serial sender.
// Assumes one 25 MHz system clock and an AXI4-Lite register port.
package wcs_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS = 40000;
	localparam int unsigned HALF_FAST_PS = 62500; // Half period of 8 MHz
	localparam int unsigned HALF_SLOW_PS = 125000; // Half period of 4 MHz
	// Least times, so they round up to whole cycles
	localparam int unsigned HALF_FAST_CYC =
		(HALF_FAST_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned HALF_SLOW_CYC =
		(HALF_SLOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [2:0] HALF_FAST_M1 = 3'(HALF_FAST_CYC - 1);
	localparam logic [2:0] HALF_SLOW_M1 = 3'(HALF_SLOW_CYC - 1);
	localparam int unsigned GAP_SCLK_CYCLES = 7;
	localparam logic [3:0] GAP_TICKS_M1 = 4'(2 * GAP_SCLK_CYCLES - 1);

	// ------------------------------------------------------------------
	// Word layout
	// ------------------------------------------------------------------
	localparam int WORD_W = 32;
	localparam int SAMPLE_W = 24;
	localparam int MAX_WORDS = 16;

	// ------------------------------------------------------------------
	// Register map and fields
	// ------------------------------------------------------------------
	localparam int AXI_ADDR_W = 4;
	localparam logic [3:0] OFF_SETUP = 4'h0;
	localparam logic [3:0] OFF_GENERAL = 4'h4;
	localparam logic [3:0] OFF_STATUS = 4'h8;
	localparam int SETUP_CLK_BIT = 0;
	localparam int SETUP_SIZE_BIT = 1;
	localparam int SETUP_GAP_BIT = 2;
	localparam int SETUP_SET_LSB = 3;
	localparam int SETUP_POL_BIT = 5;
	localparam int SETUP_USED_W = 6;
	localparam int GEN_ENABLE_BIT = 6;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ACTIVE_BIT = 1;
	localparam int STAT_SKIP_BIT = 2;
	localparam logic [5:0] SETUP_RESET = 6'h00;
	localparam logic [1:0] WSET_WAVE = 2'h1;
	localparam logic [1:0] WSET_POWER = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Word order tables; entry 0 goes out first
	localparam logic [6:0][3:0] WAVE_SEQ =
		{4'h7, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
	localparam logic [8:0][3:0] POWER_SEQ =
		{4'hf, 4'he, 4'hd, 4'hc, 4'hb, 4'ha, 4'h9, 4'h8, 4'h6};
	localparam logic [3:0] LAST_ALL = 4'hf;
	localparam logic [3:0] LAST_WAVE = 4'h6;
	localparam logic [3:0] LAST_POWER = 4'h8;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		WCS_IDLE = 2'b00,
		WCS_SHIFT = 2'b01,
		WCS_GAP = 2'b11
	} wcs_state_type;

	// Index 0 phase A current, 1 phase A voltage, 2 B current,
	// 3 B voltage, 4 C current, 5 C voltage, 6 apparent A,
	// 7 neutral current, 8 apparent B, 9 apparent C, 10..12 active A..C,
	// 13..15 fundamental reactive A..C
	typedef struct packed {
		logic [MAX_WORDS-1:0][SAMPLE_W-1:0] sample;
	} wcs_words_type;

	typedef struct packed {
		logic aw_held;
		logic [AXI_ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [7:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [WORD_W-1:0] rdata;
		logic [1:0] rresp;
		logic [SETUP_USED_W-1:0] setup;
		logic enable;
		logic skipped;
		wcs_state_type state;
		logic [SETUP_USED_W-1:0] cfg;
		logic [2:0] tick;
		logic [3:0] gap;
		logic [4:0] bit_pos;
		logic [3:0] word_n;
		logic sclk;
		logic data;
		logic sel;
		wcs_words_type snap;
	} wcs_st_type;

	// Maps a position in the transfer to a sample index
	function automatic logic [3:0] wcs_seq_index(input logic [1:0] set,
		input logic [3:0] n);
		logic [3:0] idx;
		idx = n;
		if (set == WSET_WAVE) begin
			idx = WAVE_SEQ[n[2:0]];
		end else if (set == WSET_POWER) begin
			idx = POWER_SEQ[n];
		end
		return idx;
	endfunction : wcs_seq_index

	// Position of the last word of a transfer; code 11 acts as 00
	function automatic logic [3:0] wcs_seq_last(input logic [1:0] set);
		logic [3:0] last;
		last = LAST_ALL;
		if (set == WSET_WAVE) begin
			last = LAST_WAVE;
		end else if (set == WSET_POWER) begin
			last = LAST_POWER;
		end
		return last;
	endfunction : wcs_seq_last

endpackage : wcs_pkg

/* File: rtl/wcs_top.sv */
// Waveform capture serial sender: register slave and serial master.
// Assumes sample_update, host_is_i2c and word_values come from logic on
// mclk; the serial clock is made here from mclk, so there is one domain.
//
// Function
// - Port off after reset until enable set
// - Enable only works with I2C host interface
// - Sign-extend 24-bit samples, sixteen words most
// - Device drives select, data and clock
// - Clock 8 MHz at zero, 4 MHz at one; halves rounded up to whole mclk cycles give 6.25 MHz and 3.125 MHz
// - New data bit on each falling edge
// - Package size 32 bits or 8 bits
// - Words go out most significant first
// - Gap enabled inserts seven idle clock cycles
// - No gap: back to back, size ignored
// - Word set 00 sends all sixteen words
// - Word set 01 sends seven waveform samples
// - Word set 10 sends nine power words
// - Word set 11 behaves as 00
// - Select polarity bit inverts all select levels
// - Setup bits 7 to 6 are ignored
// - Data and select pins high after reset
// - Long transfers run every other sample period
// - Short transfers run every sample period
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module wcs_top
	import wcs_pkg::*;
(
	input wire logic mclk, // System clock, 25 MHz
	input wire logic arst_n, // Asynchronous reset, active low
	input wire logic sample_update, // Waveform update pulse
	input wire logic host_is_i2c, // Host interface is I2C
	input wire wcs_words_type word_values, // Live sample words
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	output logic capture_serial_clock, // Serial clock out
	output logic capture_data_out, // Serial data out
	output logic capture_select_out // Select out
);

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	if (HALF_FAST_CYC < 1 || HALF_SLOW_CYC > 8) begin : g_bad_rate
		$error("Serial clock divider does not fit the tick counter");
	end

	// ------------------------------------------------------------------
	// State and decoded terms
	// ------------------------------------------------------------------
	wcs_st_type st;
	wcs_st_type next_st;
	logic en_eff;
	logic [1:0] set;
	logic [2:0] half_m1;
	logic [SAMPLE_W-1:0] cur_sample;
	logic [WORD_W-1:0] cur_word;
	logic word_end;
	logic pkg_end;
	logic last_word;
	logic [WORD_W-1:0] rd_value;

	// Port only runs while enabled and the host side is I2C
	assign en_eff = st.enable & host_is_i2c;
	assign set = st.cfg[SETUP_SET_LSB +: 2];
	assign half_m1 = st.cfg[SETUP_CLK_BIT] ? HALF_SLOW_M1 : HALF_FAST_M1;
	// Sign extension of the selected sample
	assign cur_sample = st.snap.sample[wcs_seq_index(set, st.word_n)];
	assign cur_word = {{(WORD_W - SAMPLE_W){cur_sample[SAMPLE_W-1]}},
		cur_sample};
	assign word_end = (st.bit_pos == 5'h1f);
	assign last_word = (st.word_n == wcs_seq_last(set));
	// Package boundary only matters when gaps are on
	assign pkg_end = st.cfg[SETUP_GAP_BIT] & (st.cfg[SETUP_SIZE_BIT] ?
		(st.bit_pos[2:0] == 3'h7) : word_end);

	// Read mux; reserved and unused bits read as zero
	always_comb begin
		rd_value = '0;
		if (s_axi_araddr == OFF_SETUP) begin
			rd_value[SETUP_USED_W-1:0] = st.setup;
		end else if (s_axi_araddr == OFF_GENERAL) begin
			rd_value[GEN_ENABLE_BIT] = st.enable;
		end else if (s_axi_araddr == OFF_STATUS) begin
			rd_value[STAT_BUSY_BIT] = (st.state != WCS_IDLE);
			rd_value[STAT_ACTIVE_BIT] = en_eff;
			rd_value[STAT_SKIP_BIT] = st.skipped;
		end
	end

	// Handshake outputs
	assign s_axi_awready = ~st.aw_held;
	assign s_axi_wready = ~st.w_held;
	assign s_axi_arready = ~st.rvalid;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	// Pins come straight from flops
	assign capture_serial_clock = st.sclk;
	assign capture_data_out = st.data;
	assign capture_select_out = st.sel;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		next_st = st;
		// Address and data are caught in either order
		if (s_axi_awvalid && !st.aw_held) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.w_held) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata[7:0];
			next_st.w_lane0 = s_axi_wstrb[0];
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		// Write commits once both halves are in and no answer waits
		if (st.aw_held && st.w_held && !st.bvalid) begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = RESP_OKAY;
			if (st.aw_addr == OFF_SETUP) begin
				// Bits 7:6 are not stored
				if (st.w_lane0) begin
					next_st.setup = st.w_data[SETUP_USED_W-1:0];
				end
			end else if (st.aw_addr == OFF_GENERAL) begin
				// An enable written under the SPI host is dropped
				if (st.w_lane0 && host_is_i2c) begin
					next_st.enable = st.w_data[GEN_ENABLE_BIT];
				end
			end else if (st.aw_addr != OFF_STATUS) begin
				next_st.bresp = RESP_SLVERR;
			end
		end
		// Read channel answers one cycle after the address
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = rd_value;
			next_st.rresp = (s_axi_araddr == OFF_SETUP ||
				s_axi_araddr == OFF_GENERAL ||
				s_axi_araddr == OFF_STATUS) ? RESP_OKAY : RESP_SLVERR;
		end

		// Serial engine; a disabled port parks every pin at idle
		if (!en_eff) begin
			next_st.state = WCS_IDLE;
			next_st.sclk = 1'b1;
			next_st.data = 1'b1;
			next_st.sel = ~st.setup[SETUP_POL_BIT];
		end else begin
			unique case (st.state)
				WCS_IDLE: begin
					next_st.sclk = 1'b1;
					next_st.data = 1'b1;
					next_st.sel = ~st.setup[SETUP_POL_BIT];
					// Snapshot words and setup so edits mid-frame are harmless
					if (sample_update) begin
						next_st.state = WCS_SHIFT;
						next_st.snap = word_values;
						next_st.cfg = st.setup;
						next_st.word_n = '0;
						next_st.bit_pos = '0;
						next_st.skipped = 1'b0;
						next_st.tick = st.setup[SETUP_CLK_BIT] ?
							HALF_SLOW_M1 : HALF_FAST_M1;
						next_st.sel = st.setup[SETUP_POL_BIT];
					end
				end
				WCS_SHIFT: begin
					if (st.tick != 3'h0) begin
						next_st.tick = st.tick - 3'h1;
					end else begin
						next_st.tick = half_m1;
						if (st.sclk) begin
							// Falling edge carries the next bit, MSB first
							next_st.sclk = 1'b0;
							next_st.data = cur_word[5'h1f - st.bit_pos];
						end else begin
							next_st.sclk = 1'b1;
							next_st.bit_pos = st.bit_pos + 5'h1;
							if (word_end && last_word) begin
								// Data and select hold past the last rise, so
								// the slave never sees them move on its edge
								next_st.state = WCS_IDLE;
							end else begin
								if (word_end) begin
									next_st.word_n = st.word_n + 4'h1;
								end
								if (pkg_end) begin
									next_st.state = WCS_GAP;
									next_st.gap = GAP_TICKS_M1;
								end
							end
						end
					end
				end
				WCS_GAP: begin
					// Clock rests high while select is inactive; select
					// drops one cycle after the rise that ends the package
					next_st.sel = ~st.cfg[SETUP_POL_BIT];
					if (st.tick != 3'h0) begin
						next_st.tick = st.tick - 3'h1;
					end else begin
						next_st.tick = half_m1;
						if (st.gap == 4'h0) begin
							next_st.state = WCS_SHIFT;
							next_st.sel = st.cfg[SETUP_POL_BIT];
						end else begin
							next_st.gap = st.gap - 4'h1;
						end
					end
				end
				default: begin
					next_st.state = WCS_IDLE;
				end
			endcase
			// An update during a frame is skipped: half rate results
			if (sample_update && st.state != WCS_IDLE) begin
				next_st.skipped = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
			st.sclk <= 1'b1;
			st.data <= 1'b1;
			st.sel <= 1'b1;
			st.setup <= SETUP_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	a_off_goes_idle: assert property (
		!en_eff |=> st.state == WCS_IDLE && st.data && st.sclk)
		else $error("Port active while disabled");

	a_spi_blocks_enable: assert property (
		!host_is_i2c |-> st.state == WCS_IDLE || $past(host_is_i2c))
		else $error("Port ran under the SPI host");

	a_data_on_fall: assert property (
		st.state == WCS_SHIFT && $past(st.state) == WCS_SHIFT &&
		$changed(st.data) |-> $fell(st.sclk))
		else $error("Data moved away from a falling edge");

	a_fast_low_half: assert property (
		$fell(st.sclk) && !st.cfg[SETUP_CLK_BIT] |->
		!st.sclk ##1 !st.sclk ##1 st.sclk)
		else $error("Fast serial clock low time wrong");

	a_slow_low_half: assert property (
		$fell(st.sclk) && st.cfg[SETUP_CLK_BIT] |->
		!st.sclk[*4] ##1 st.sclk)
		else $error("Slow serial clock low time wrong");

	a_sign_bits: assert property (
		$fell(st.sclk) && $past(st.bit_pos) < 5'h08 |->
		st.data == $past(cur_sample[SAMPLE_W-1]))
		else $error("Upper bits are not the sign");

	a_gap_length: assert property (
		$rose(st.state == WCS_GAP) && !st.cfg[SETUP_CLK_BIT] |->
		##27 st.state == WCS_GAP ##1 st.state == WCS_SHIFT)
		else $error("Gap is not seven serial clocks");

	a_no_gap_off: assert property (
		!st.cfg[SETUP_GAP_BIT] && st.state == WCS_SHIFT |=>
		st.state != WCS_GAP)
		else $error("Gap without gap enable");

	a_select_level: assert property (
		st.state == WCS_SHIFT |-> st.sel == st.cfg[SETUP_POL_BIT])
		else $error("Select not active during a package");

	a_word_count: assert property (
		$past(st.state) == WCS_SHIFT && st.state == WCS_IDLE && en_eff
		&& $past(en_eff) |-> $past(st.word_n) == wcs_seq_last(set))
		else $error("Transfer ended on the wrong word");

	// Slave samples on the rise, so nothing it reads may move there
	a_data_hold_rise: assert property (
		$rose(st.sclk) |-> $stable(st.data))
		else $error("Data moved on a rising edge");

	a_select_hold_rise: assert property (
		$rose(st.sclk) |-> $stable(st.sel))
		else $error("Select moved on a rising edge");

	a_gap_select_idle: assert property (
		st.state == WCS_GAP && $past(st.state) == WCS_GAP |->
		st.sel != st.cfg[SETUP_POL_BIT])
		else $error("Select active inside a gap");

	a_idle_pins_high: assert property (
		st.state == WCS_IDLE && $past(st.state) == WCS_IDLE |->
		st.data && st.sclk)
		else $error("Idle data or clock not high");

	a_busy_update_skip: assert property (
		en_eff && sample_update && st.state != WCS_IDLE |=> st.skipped)
		else $error("Update during a frame not skipped");

	a_slow_gap_length: assert property (
		$rose(st.state == WCS_GAP) && st.cfg[SETUP_CLK_BIT] |->
		##55 st.state == WCS_GAP ##1 st.state == WCS_SHIFT)
		else $error("Slow gap is not seven serial clocks");

	a_first_fall_fast: assert property (
		$past(st.state) == WCS_IDLE && st.state == WCS_SHIFT &&
		!st.cfg[SETUP_CLK_BIT] |-> st.sclk ##1 st.sclk ##1 !st.sclk)
		else $error("First fast clock fall misplaced");

endmodule : wcs_top

/* File: sim/tb_waveform_capture_serial_tx.sv */
// Testbench for the capture port sender, registers over AXI4-Lite.
// Assumes 25 MHz mclk and a 125 us waveform update period.
`timescale 1ns/1ns
module tb_waveform_capture_serial_tx
	import wcs_pkg::*;
;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam int UPD_CYC = 3125; // 125 us in 40 ns cycles
	logic mclk = 1'h0, arst_n = 1'h0, upd = 1'h0, i2c = 1'h1;
	logic pol = 1'h0, clr = 1'h0;
	wcs_words_type wv = '0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, sclk, sd, sel;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int n_errors = 0, cmp_count = 0, hi_run = 0, hi_max = 0;

	wcs_top i_dut (.mclk(mclk), .arst_n(arst_n), .sample_update(upd),
		.host_is_i2c(i2c), .word_values(wv), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .capture_serial_clock(sclk),
		.capture_data_out(sd), .capture_select_out(sel));
	wcs_rx_model rx (.sclk(sclk), .sdata(sd), .sel(sel), .pol(pol),
		.clr(clr));

	always #20 mclk = ~mclk; // 25 MHz

	// Longest serial clock high stretch ending in a fall; an update
	// restarts it so idle time never counts as a gap
	always @(posedge mclk) begin
		if (upd) begin
			hi_run = 0;
		end else if (sclk) begin
			hi_run++;
		end else begin
			if (hi_run > hi_max) hi_max = hi_run;
			hi_run = 0;
		end
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic finish_test;
		$display("Compares %0d, errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	// Write: address and data offered together, each released when taken
	task automatic axw(input logic [3:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		n = 0;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			n++;
		end while (bvalid !== 1'h1 && n < 100);
		if (bvalid !== 1'h1) begin
			n_errors++;
			$display("Error axi write expected bvalid seen timeout");
		end
		r = bresp;
		bready <= 1'h0;
	endtask : axw

	task automatic axr(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		n = 0;
		do begin
			@(posedge mclk);
			if (arready) arvalid <= 1'h0;
			n++;
		end while (rvalid !== 1'h1 && n < 100);
		if (rvalid !== 1'h1) begin
			n_errors++;
			$display("Error axi read expected rvalid seen timeout");
		end
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask : axr

	task automatic pulse;
		@(posedge mclk);
		upd <= 1'h1;
		@(posedge mclk);
		upd <= 1'h0;
	endtask : pulse

	task automatic clr_rx;
		@(posedge mclk);
		clr <= 1'h1;
		@(posedge mclk);
		clr <= 1'h0;
	endtask : clr_rx

	function automatic logic [23:0] val(input int i, input logic flip);
		logic [23:0] v;
		v = {i[0], 7'(i), 16'ha5c3 ^ 16'(i)};
		return flip ? ~v : v;
	endfunction : val

	// Sample index sent at position n for a word set code
	function automatic int exp_idx(input logic [1:0] c, input int n);
		if (c == 2'h1) return (n < 6) ? n : 7;
		if (c == 2'h2) return (n == 0) ? 6 : n + 7;
		return n;
	endfunction : exp_idx

	task automatic set_words(input logic flip);
		for (int i = 0; i < MAX_WORDS; i++) wv.sample[i] <= val(i, flip);
	endtask : set_words

	task automatic wait_bits(input int nb);
		int n;
		n = 0;
		while (n < 20000 && (rx.n_bits < nb || sel !== ~pol)) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 20000) begin
			n_errors++;
			$display("Error frame end expected %0d bits seen timeout", nb);
		end
	endtask : wait_bits

	// One transfer; words change right after the update to catch a
	// design that sends live values instead of the snapshot
	task automatic run(input logic [7:0] cfg);
		logic [1:0] r;
		logic [1:0] c;
		logic [23:0] s;
		int nw;
		c = cfg[4:3];
		nw = (c == 2'h1) ? 7 : (c == 2'h2) ? 9 : 16;
		axw(OFF_SETUP, {24'h00_0000, cfg}, r);
		clr_rx();
		hi_max = 0;
		pulse();
		set_words(1'h1);
		wait_bits(nw * 32);
		set_words(1'h0);
		for (int n = 0; n < nw; n++) begin
			s = val(exp_idx(c, n), 1'h0);
			chk("word", {{8{s[23]}}, s}, rx.words[n]);
		end
	endtask : run

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		chk("data pin", 32'h0000_0001, sd);
		chk("select pin", 32'h0000_0001, sel);
		clr_rx();
		axr(OFF_SETUP, d, r);
		chk("setup reset", 32'h0000_0000, d);
		axr(OFF_GENERAL, d, r);
		chk("enable reset", 32'h0000_0000, d[GEN_ENABLE_BIT]);
		axr(4'hc, d, r);
		chk("unmapped resp", RESP_SLVERR, r);
		pulse();
		repeat (100) @(posedge mclk);
		chk("bits while off", 32'h0000_0000, rx.n_bits);
		$display("test reset done");
	endtask : t_reset

	task automatic t_host;
		logic [31:0] d;
		logic [1:0] r;
		i2c <= 1'h0;
		axw(OFF_GENERAL, 32'h0000_0040, r);
		axr(OFF_GENERAL, d, r);
		chk("enable under spi", 32'h0000_0000, d[GEN_ENABLE_BIT]);
		pulse();
		repeat (100) @(posedge mclk);
		chk("bits under spi", 32'h0000_0000, rx.n_bits);
		i2c <= 1'h1;
		axw(OFF_GENERAL, 32'h0000_0040, r);
		axr(OFF_GENERAL, d, r);
		chk("enable", 32'h0000_0001, d[GEN_ENABLE_BIT]);
		$display("test host done");
	endtask : t_host

	// Every word set code, reserved setup bits set all along
	task automatic t_sets;
		logic [31:0] d;
		logic [1:0] r;
		for (int c = 0; c < 4; c++) begin
			run({2'h3, 1'h0, 2'(c), 3'h0});
			chk("clock high", HALF_FAST_CYC, hi_max);
		end
		axr(OFF_SETUP, d, r);
		chk("setup read", 32'h0000_0018, d);
		$display("test sets done");
	endtask : t_sets

	task automatic t_gap;
		for (int s = 0; s < 2; s++) begin
			run({5'h01, 1'h1, 1'(s), 1'h0});
			chk("packages", s ? 28 : 7, rx.n_pkts);
			chk("gap length", 15 * HALF_FAST_CYC, hi_max);
		end
		$display("test gap done");
	endtask : t_gap

	task automatic t_pol;
		pol <= 1'h1;
		run(8'h28);
		chk("packages", 32'h0000_0001, rx.n_pkts);
		chk("idle select", 32'h0000_0000, sel);
		pol <= 1'h0;
		$display("test polarity done");
	endtask : t_pol

	// Three updates: the slow full set must drop the middle one
	task automatic t_rate;
		logic [1:0] r;
		for (int f = 0; f < 2; f++) begin
			axw(OFF_SETUP, f ? 32'h0000_0000 : 32'h0000_0001, r);
			clr_rx();
			hi_max = 0;
			repeat (3) begin
				pulse();
				repeat (UPD_CYC - 2) @(posedge mclk);
			end
			wait_bits(f ? 1536 : 1024);
			chk("bits", f ? 1536 : 1024, rx.n_bits);
			chk("clock high", f ? HALF_FAST_CYC : HALF_SLOW_CYC, hi_max);
		end
		$display("test rate done");
	endtask : t_rate

	// ------------------------------------------------------------
	// Sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		set_words(1'h0);
		repeat (3) @(posedge mclk);
		arst_n <= 1'h1;
		t_reset();
		t_host();
		t_sets();
		t_gap();
		t_pol();
		t_rate();
		finish_test();
	end

	// Tests need about 30000 cycles; twice that as margin
	initial begin
		repeat (60000) @(posedge mclk);
		n_errors++;
		$display("Error watchdog expected done seen timeout");
		finish_test();
	end
endmodule : tb_waveform_capture_serial_tx

/* File: sim/wcs_rx_model.sv */
// Slave model for the capture port: records what arrives on the wire.
// Assumes select is active when it equals the polarity input.
`timescale 1ns/1ns
module wcs_rx_model (
	input wire logic sclk, // Serial clock from the device
	input wire logic sdata, // Serial data from the device
	input wire logic sel, // Select from the device
	input wire logic pol, // Active level of select
	input wire logic clr // Clears the record
);
	logic [31:0] shift;
	logic [31:0] words [0:63];
	int n_bits;
	int n_pkts;

	// Clear between frames so each test starts from nothing
	always @(posedge clr) begin
		n_bits = 0;
		n_pkts = 0;
	end

	// Sample only on the rising edge, so late data shows up as bad words
	always @(posedge sclk) begin
		if (sel === pol && !clr) begin
			shift = {shift[30:0], sdata};
			n_bits++;
			if (n_bits % 32 == 0) words[(n_bits / 32 - 1) % 64] = shift;
		end
	end

	// A package starts where select turns active
	always @(sel) begin
		if (sel === pol && !clr) n_pkts++;
	end
endmodule : wcs_rx_model
